// *** psb_burst_if.sv ***
// Burst interface of the pseudo-static RAM, device side
`timescale 1ns/1ns
// Overview of operation
// - Select low 10 us ends deep sleep
// - No bursts before 150 us initialization
// - Suspended read keeps driving valid data
// - Refresh collision stretches read wait to double
// - Read latency is code plus one clocks
// - Write wait lasts code clocks
// - Select may stay low between bursts
// - New burst accepted after first word
module psb_burst_if #(
    parameter int ADDR_W = psb_pkg::ADDR_W,
    parameter int ROW_W = psb_pkg::ROW_W
) (
    // System side
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire psb_pkg::psb_cfg_type i_cfg,
    input wire logic i_dpd_enter,
    output logic o_init_done,
    output logic o_deep_sleep,
    // Link side
    input wire logic i_link_clk,
    input wire psb_pkg::psb_link_in_type i_link,
    output logic [psb_pkg::DATA_W-1:0] o_dq,
    output logic o_dq_oe,
    output logic o_wait,
    output logic o_wait_oe
);
    localparam int LAT_W = psb_pkg::LAT_W;
    localparam int CNT_W = psb_pkg::CNT_W;
    // ==========================================================
    // System domain: initialization, deep sleep, refresh timer
    psb_pkg::psb_sys_state_type sys_state_reg, sys_state_next;
    logic [CNT_W-1:0] sys_cnt_reg, sys_cnt_next;   // Init and sleep timer
    logic [CNT_W-1:0] low_cnt_reg, low_cnt_next;   // Select low time in sleep
    logic [CNT_W-1:0] ref_cnt_reg, ref_cnt_next;   // Refresh interval timer
    logic ref_tgl_reg, ref_tgl_next;               // Toggles once per refresh request
    logic ce_s1_reg, ce_s2_reg, ce_s3_reg;         // Select pin synchroniser
    logic ce_low_reg, ce_low_next;                 // Filtered select low level
    logic init_done_next, deep_sleep_next;

    // Next-state logic of the system domain
    always_comb begin
        sys_state_next = sys_state_reg;
        sys_cnt_next = sys_cnt_reg;
        low_cnt_next = low_cnt_reg;
        ref_cnt_next = ref_cnt_reg;
        ref_tgl_next = ref_tgl_reg;
        // A change counts once the second and third stage agree
        ce_low_next = (ce_s2_reg == ce_s3_reg) ? ~ce_s3_reg : ce_low_reg;
        unique case (sys_state_reg)
            psb_pkg::SYS_INIT: begin
                // Bursts stay locked out until the whole period has run
                if (sys_cnt_reg == CNT_W'(psb_pkg::INIT_CYC - 1)) begin
                    sys_state_next = psb_pkg::SYS_RUN;
                    sys_cnt_next = '0;
                end else begin
                    sys_cnt_next = sys_cnt_reg + 1'b1;
                end
            end
            psb_pkg::SYS_RUN: begin
                // Refresh requests only exist while the array is alive
                if (ref_cnt_reg == CNT_W'(psb_pkg::REFRESH_CYC - 1)) begin
                    ref_cnt_next = '0;
                    ref_tgl_next = ~ref_tgl_reg;
                end else begin
                    ref_cnt_next = ref_cnt_reg + 1'b1;
                end
                if (i_dpd_enter) begin
                    sys_state_next = psb_pkg::SYS_SLEEP;
                    sys_cnt_next = '0;
                    low_cnt_next = '0;
                end
            end
            psb_pkg::SYS_SLEEP: begin
                // Exit attempts before the least stay are ignored
                if (sys_cnt_reg != CNT_W'(psb_pkg::DPD_MIN_CYC)) begin
                    sys_cnt_next = sys_cnt_reg + 1'b1;
                    low_cnt_next = '0;
                end else if (!ce_low_reg) begin
                    low_cnt_next = '0;
                end else if (low_cnt_reg == CNT_W'(psb_pkg::DPD_EXIT_CYC - 1)) begin
                    // Array contents are lost, so a full initialization follows
                    sys_state_next = psb_pkg::SYS_INIT;
                    sys_cnt_next = '0;
                end else begin
                    low_cnt_next = low_cnt_reg + 1'b1;
                end
            end
            default: sys_state_next = psb_pkg::SYS_INIT;
        endcase
        init_done_next = (sys_state_next == psb_pkg::SYS_RUN);
        deep_sleep_next = (sys_state_next == psb_pkg::SYS_SLEEP);
    end

    // Registers of the system domain
    always_ff @(posedge i_sys_clk) begin
        ce_s1_reg <= i_link.ce_n;
        ce_s2_reg <= ce_s1_reg;
        ce_s3_reg <= ce_s2_reg;
        if (i_srst) begin
            sys_state_reg <= psb_pkg::SYS_INIT;
            sys_cnt_reg <= '0;
            low_cnt_reg <= '0;
            ref_cnt_reg <= '0;
            ref_tgl_reg <= 1'b0;
            ce_low_reg <= 1'b0;
            o_init_done <= 1'b0;
            o_deep_sleep <= 1'b0;
        end else begin
            sys_state_reg <= sys_state_next;
            sys_cnt_reg <= sys_cnt_next;
            low_cnt_reg <= low_cnt_next;
            ref_cnt_reg <= ref_cnt_next;
            ref_tgl_reg <= ref_tgl_next;
            ce_low_reg <= ce_low_next;
            o_init_done <= init_done_next;
            o_deep_sleep <= deep_sleep_next;
        end
    end

    // ==========================================================
    // Crossings into the link domain
    logic rst_s1_reg, link_rst;                    // Reset carried onto the link clock
    logic rdy_s1_reg, rdy_s2_reg, rdy_s3_reg;      // Ready level
    logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;      // Refresh toggle
    psb_pkg::psb_cfg_type cfg_s1_reg, cfg_s2_reg, cfg_s3_reg, cfg_reg;
    logic rdy, ref_edge;

    // Three-stage synchronisers, two stages for the reset, first stage read only by the second
    always_ff @(posedge i_link_clk) begin
        rst_s1_reg <= i_srst;
        link_rst <= rst_s1_reg;
        rdy_s1_reg <= o_init_done;
        rdy_s2_reg <= rdy_s1_reg;
        rdy_s3_reg <= rdy_s2_reg;
        tgl_s1_reg <= ref_tgl_reg;
        tgl_s2_reg <= tgl_s1_reg;
        tgl_s3_reg <= tgl_s2_reg;
        cfg_s1_reg <= i_cfg;
        cfg_s2_reg <= cfg_s1_reg;
        cfg_s3_reg <= cfg_s2_reg;
        // Configuration is taken only once two stages agree
        if (cfg_s2_reg == cfg_s3_reg) begin
            cfg_reg <= cfg_s3_reg;
        end
    end
    assign rdy = rdy_s2_reg & rdy_s3_reg;
    assign ref_edge = tgl_s2_reg ^ tgl_s3_reg;

    // ==========================================================
    // Link domain: burst sequencing on the controller's clock
    psb_pkg::psb_link_state_type lst_reg, lst_next;
    logic [LAT_W-1:0] lat_reg, lat_next;           // Clocks left in the latency
    logic [ADDR_W-1:0] addr_reg, addr_next;        // Current word address
    logic is_wr_reg, is_wr_next;                   // Burst direction
    logic first_reg, first_next;                   // First word has moved
    logic ref_pend_reg, ref_pend_next;             // Refresh waiting for the array
    logic [psb_pkg::DATA_W-1:0] dq_next;
    logic dq_oe_next, wait_next, wait_oe_next;
    logic start, collide, wr_en;
    logic [LAT_W-1:0] code;
    logic [1:0][7:0] mem_array [0:(2**ADDR_W)-1];  // Array, one entry per word
    logic [1:0] lane_we;                           // Write strobe per byte lane

    // Next-state logic of the link domain
    always_comb begin
        lst_next = lst_reg;
        lat_next = lat_reg;
        addr_next = addr_reg;
        is_wr_next = is_wr_reg;
        first_next = first_reg;
        dq_next = o_dq;
        wr_en = 1'b0;
        wait_oe_next = ~i_link.ce_n;
        code = LAT_W'(cfg_reg.latency_count);
        collide = ~cfg_reg.fixed_latency & ref_pend_reg;
        // New bursts only once ready, and mid-burst only after the first word
        start = ~i_link.ce_n & ~i_link.address_valid_n & rdy
            & ((lst_reg == psb_pkg::L_IDLE) | ((lst_reg == psb_pkg::L_DATA) & first_reg));
        // Set wins over clear: a request landing on a collision stays pending
        ref_pend_next = (ref_pend_reg & ~(start & i_link.we_n & collide)) | ref_edge;
        if (i_link.ce_n) begin
            lst_next = psb_pkg::L_IDLE;
        end else if (start) begin
            // Select may stay low from one burst into the next
            addr_next = i_link.addr;
            is_wr_next = ~i_link.we_n;
            first_next = 1'b0;
            lst_next = psb_pkg::L_LAT;
            if (!i_link.we_n) begin
                lat_next = code;
                if (code == '0) begin
                    lst_next = psb_pkg::L_DATA;
                end
            end else if (collide) begin
                lat_next = LAT_W'((code + 1'b1) << 1);
            end else begin
                lat_next = code + 1'b1;
            end
        end else begin
            unique case (lst_reg)
                psb_pkg::L_IDLE: lst_next = psb_pkg::L_IDLE;
                psb_pkg::L_LAT: begin
                    lat_next = lat_reg - 1'b1;
                    if (lat_reg == LAT_W'(1)) begin
                        lst_next = psb_pkg::L_DATA;
                        dq_next = mem_array[addr_reg];
                    end
                end
                psb_pkg::L_DATA: begin
                    first_next = 1'b1;
                    wr_en = is_wr_reg;
                    if (!cfg_reg.wrap_en && (&addr_reg[ROW_W-1:0])) begin
                        // Row boundary: hold wait until the controller ends it
                        lst_next = psb_pkg::L_ROW_END;
                    end else begin
                        addr_next[ROW_W-1:0] = addr_reg[ROW_W-1:0] + 1'b1;
                        if (!cfg_reg.wrap_en) begin
                            addr_next = addr_reg + 1'b1;
                        end
                        dq_next = mem_array[addr_next];
                    end
                end
                psb_pkg::L_ROW_END: lst_next = psb_pkg::L_ROW_END;
            endcase
        end
        // Early wait timing drops wait one clock ahead of the data
        wait_next = ((lst_next == psb_pkg::L_LAT) & (lat_next > LAT_W'(cfg_reg.wait_timing)))
            | (lst_next == psb_pkg::L_ROW_END);
        // Stopped clock freezes these flops, so data stays valid
        dq_oe_next = (lst_next == psb_pkg::L_DATA) & ~is_wr_next & ~i_link.oe_n;
    end

    // Registers of the link domain
    always_ff @(posedge i_link_clk) begin
        if (link_rst) begin
            lst_reg <= psb_pkg::L_IDLE;
            lat_reg <= '0;
            addr_reg <= '0;
            is_wr_reg <= 1'b0;
            first_reg <= 1'b0;
            ref_pend_reg <= 1'b0;
            o_dq <= '0;
            o_dq_oe <= 1'b0;
            o_wait <= 1'b0;
            o_wait_oe <= 1'b0;
        end else begin
            lst_reg <= lst_next;
            lat_reg <= lat_next;
            addr_reg <= addr_next;
            is_wr_reg <= is_wr_next;
            first_reg <= first_next;
            ref_pend_reg <= ref_pend_next;
            o_dq <= dq_next;
            o_dq_oe <= dq_oe_next;
            o_wait <= wait_next;
            o_wait_oe <= wait_oe_next;
        end
    end

    // Lane strobes, a masked lane keeps its old byte
    for (genvar g = 0; g < 2; g++) begin : g_lane
        assign lane_we[g] = wr_en
            & ~(g == 0 ? i_link.lower_byte_select_n : i_link.upper_byte_select_n);
    end

    // One writer process for the array, so both lanes share a single driver
    always_ff @(posedge i_link_clk) begin
        for (int b = 0; b < 2; b++) begin
            if (lane_we[b]) begin
                mem_array[addr_reg][b] <= i_link.dq[b*8 +: 8];
            end
        end
    end

    // ==========================================================
    // Checks
    chk_init_period: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(o_init_done) |-> $past(sys_cnt_reg) == CNT_W'(psb_pkg::INIT_CYC - 1))
        else $error("init done before full period");
    chk_sleep_stay: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $fell(o_deep_sleep) |-> $past(sys_cnt_reg) == CNT_W'(psb_pkg::DPD_MIN_CYC))
        else $error("deep sleep left too early");
    chk_sleep_exit: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $fell(o_deep_sleep) |-> $past(low_cnt_reg) == CNT_W'(psb_pkg::DPD_EXIT_CYC - 1)
        && !o_init_done)
        else $error("deep sleep exit without select low time");
    chk_read_latency: assert property (@(posedge i_link_clk) disable iff (link_rst)
        start && i_link.we_n && !collide |=> lat_reg == $past(code) + 1'b1)
        else $error("read latency not code plus one");
    chk_write_wait: assert property (@(posedge i_link_clk) disable iff (link_rst)
        start && !i_link.we_n |=> lat_reg == $past(code))
        else $error("write wait not code cycles");
    chk_collide_wait: assert property (@(posedge i_link_clk) disable iff (link_rst)
        start && i_link.we_n && collide |=> lat_reg == LAT_W'(($past(code) + 1'b1) << 1))
        else $error("collision wait not doubled");
    chk_suspend_drive: assert property (@(posedge i_link_clk) disable iff (link_rst)
        o_dq_oe |-> lst_reg == psb_pkg::L_DATA && !is_wr_reg && !$past(i_link.oe_n))
        else $error("data driven outside read data phase");
    chk_no_early_cut: assert property (@(posedge i_link_clk) disable iff (link_rst)
        lst_reg == psb_pkg::L_LAT && lat_reg > LAT_W'(1) && !i_link.ce_n
        |=> lst_reg == psb_pkg::L_LAT && lat_reg == $past(lat_reg) - 1'b1)
        else $error("burst cut before first word");
    chk_wait_held: assert property (@(posedge i_link_clk) disable iff (link_rst)
        lst_reg == psb_pkg::L_LAT && lat_reg > LAT_W'(2) && !i_link.ce_n |=> o_wait)
        else $error("wait dropped during latency");
    chk_ready_gate: assert property (@(posedge i_link_clk) disable iff (link_rst)
        lst_reg == psb_pkg::L_IDLE && !rdy |=> lst_reg != psb_pkg::L_LAT)
        else $error("burst taken before initialization");
    cov_collide_read: cover property (@(posedge i_link_clk) disable iff (link_rst)
        start && i_link.we_n && collide);
    cov_write_burst: cover property (@(posedge i_link_clk) disable iff (link_rst)
        wr_en ##1 wr_en);
    cov_interrupt: cover property (@(posedge i_link_clk) disable iff (link_rst)
        start && lst_reg == psb_pkg::L_DATA);
    cov_sleep_exit: cover property (@(posedge i_sys_clk) disable iff (i_srst)
        $fell(o_deep_sleep));
endmodule : psb_burst_if

// *** psb_ctrl_model.sv ***
// Memory controller model that drives the burst link of the RAM
`timescale 1ns/1ns
module psb_ctrl_model (
    // Controller pins
    output logic o_link_clk,
    output psb_pkg::psb_link_in_type o_link,
    // Device answers
    input wire logic [psb_pkg::DATA_W-1:0] i_dq,
    input wire logic i_dq_oe,
    input wire logic i_wait
);
    // ==========================================================
    // State seen by the bench
    logic run; // Clock gate, off outside frames
    logic [psb_pkg::DATA_W-1:0] rq[$]; // Words read in the last burst
    int wait_cnt; // Wait cycles seen in the last burst
    logic susp_ok; // Data held through the last suspend
    logic [1:0] lanes_n; // Byte lanes masked in bursts, bit 1 upper, 1 = masked
    initial begin
        run = 1'b1;
        lanes_n = 2'b00;
        o_link_clk = 1'b0;
        o_link = '1;
        susp_ok = 1'b0;
    end
    // ==========================================================
    // Link clock, 30 ns, parked at its level while stopped
    always begin
        #15;
        if (run) begin
            o_link_clk = ~o_link_clk;
        end
    end
    // A few clocks with select high, then park
    task automatic idle(input int n);
        run = 1'b1;
        repeat (n) @(posedge o_link_clk);
        run = 1'b0;
    endtask : idle
    // Select level without a clock, used to end deep sleep
    task automatic select(input logic v);
        o_link.ce_n <= v;
    endtask : select
    // One burst; keep leaves select low so the next call interrupts it
    task automatic burst(input logic wr, input logic [psb_pkg::ADDR_W-1:0] a, input int code,
        input logic [psb_pkg::DATA_W-1:0] wd[$], input int n, input logic keep,
        input int stop_at, output int lat);
        int k;
        int got;
        logic [psb_pkg::DATA_W-1:0] held;
        rq.delete();
        lat = 0;
        got = 0;
        wait_cnt = 0;
        run = 1'b1;
        @(posedge o_link_clk);
        // Address, strobe and direction go out with select
        o_link.ce_n <= 1'b0;
        o_link.address_valid_n <= 1'b0;
        o_link.we_n <= ~wr;
        o_link.oe_n <= wr;
        o_link.upper_byte_select_n <= lanes_n[1];
        o_link.lower_byte_select_n <= lanes_n[0];
        o_link.addr <= a;
        for (k = 0; k < 60 && got < n; k++) begin
            @(posedge o_link_clk);
            o_link.address_valid_n <= 1'b1;
            wait_cnt += (k > 0 && i_wait === 1'b1) ? 1 : 0;
            if (wr && k >= code) begin
                // Write words follow the configured latency, one per clock
                o_link.dq <= wd[got];
                got++;
            end else if (!wr && k > 0 && i_dq_oe === 1'b1) begin
                lat = (got == 0) ? k - 1 : lat;
                rq.push_back(i_dq);
                got++;
                if (got == stop_at) begin
                    // Suspend: clock parked high, no rising edge meanwhile
                    // The word shown while parked is the next one, taken after resume
                    run = 1'b0;
                    #1;
                    held = i_dq;
                    #249;
                    susp_ok = (i_dq === held) && (i_dq_oe === 1'b1);
                    run = 1'b1;
                end
            end
        end
        // Last write word is taken one edge later
        if (wr) begin
            @(posedge o_link_clk);
            wait_cnt += (i_wait === 1'b1) ? 1 : 0;
        end
        if (!keep) begin
            // Release select, short write strobe, refresh chance before parking
            o_link.ce_n <= 1'b1;
            o_link.we_n <= 1'b1;
            o_link.oe_n <= 1'b1;
            o_link.dq <= ~o_link.dq;
            repeat (3) @(posedge o_link_clk);
            run = 1'b0;
        end
    endtask : burst
endmodule : psb_ctrl_model

// *** psb_pkg.sv ***
// Shared constants and carrier types of the pseudo-static RAM burst interface
package psb_pkg;
    // ==========================================================
    // Widths
    localparam int ADDR_W = 22;            // 4M words
    localparam int DATA_W = 16;            // Word width
    localparam int LC_W = 3;               // Latency code field width
    localparam int LAT_W = 5;              // Latency counter, holds twice code plus one
    localparam int CNT_W = 12;             // System-side counters
    localparam int ROW_W = 7;              // Column bits of one row
    // ==========================================================
    // Timing, figures as printed and derived counts
    localparam int SYS_CLK_NS = 100;       // System clock period
    localparam int INIT_TIME_NS = 150000;  // Initialization period
    localparam int DPD_MIN_NS = 150000;    // Least stay in deep sleep
    localparam int DPD_EXIT_NS = 10000;    // Select low time that ends deep sleep
    localparam int REFRESH_NS = 1000;      // Internal refresh request interval
    // Refresh interval and initialization period round down, sleep times round up
    localparam int INIT_CYC = INIT_TIME_NS / SYS_CLK_NS;
    localparam int DPD_MIN_CYC = (DPD_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int DPD_EXIT_CYC = (DPD_EXIT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int REFRESH_CYC = REFRESH_NS / SYS_CLK_NS;
    // ==========================================================
    // Pins driven by the memory controller, sampled on its clock
    typedef struct packed {
        logic ce_n;                        // Chip select
        logic address_valid_n;             // Address strobe
        logic we_n;                        // Write enable
        logic oe_n;                        // Output enable
        logic upper_byte_select_n;         // Lane 1 enable
        logic lower_byte_select_n;         // Lane 0 enable
        logic [ADDR_W-1:0] addr;           // Word address
        logic [DATA_W-1:0] dq;             // Write data
    } psb_link_in_type;
    // Burst configuration, a copy of the burst_config_reg fields
    typedef struct packed {
        logic [LC_W-1:0] latency_count;    // Latency code
        logic fixed_latency;               // 1: fixed, 0: variable
        logic wait_timing;                 // 1: wait one clock ahead of data
        logic wrap_en;                     // Wrap within the row
    } psb_cfg_type;
    // ==========================================================
    // States
    typedef enum logic [1:0] {SYS_INIT, SYS_RUN, SYS_SLEEP} psb_sys_state_type;
    typedef enum logic [1:0] {L_IDLE, L_LAT, L_DATA, L_ROW_END} psb_link_state_type;
endpackage : psb_pkg

// *** testbench.sv ***
// Self-checking bench of the burst interface with a controller model
`timescale 1ns/1ns
module testbench;
    // ==========================================================
    // Stimulus, outputs and bookkeeping
    logic sys_clk = 1'b0;
    logic srst;
    logic dpd_enter;
    psb_pkg::psb_cfg_type cfg;
    logic init_done;
    logic deep_sleep;
    logic [psb_pkg::DATA_W-1:0] dq;
    logic dq_oe;
    logic wait_q;
    logic wait_oe;
    logic link_clk;
    psb_pkg::psb_link_in_type link;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0; // System clock count
    int rel;
    int lat;
    logic [psb_pkg::DATA_W-1:0] wq[$];
    logic [psb_pkg::DATA_W-1:0] noq[$]; // Empty list for reads
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    // ==========================================================
    // Design and controller model
    psb_burst_if i_dut (
        .i_sys_clk(sys_clk), .i_srst(srst), .i_cfg(cfg), .i_dpd_enter(dpd_enter),
        .o_init_done(init_done), .o_deep_sleep(deep_sleep), .i_link_clk(link_clk),
        .i_link(link), .o_dq(dq), .o_dq_oe(dq_oe), .o_wait(wait_q), .o_wait_oe(wait_oe)
    );
    psb_ctrl_model i_ctrl (
        .o_link_clk(link_clk), .o_link(link), .i_dq(dq), .i_dq_oe(dq_oe), .i_wait(wait_q)
    );
    // ==========================================================
    // Compare, count and report
    task automatic check(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    // Write four words, read them back, judge wait length and latency
    task automatic wr_rd(input int code, input logic var_lat, input int stop_at);
        logic [psb_pkg::ADDR_W-1:0] a;
        int j;
        a = 22'h000100 + 22'(code * 8 + stop_at * 64);
        wq.delete();
        for (j = 0; j < 4; j++) wq.push_back(16'h3c00 + 16'(code * 16 + stop_at * 4 + j));
        i_ctrl.burst(1'b1, a, code, wq, 4, 1'b0, 0, lat);
        check(i_ctrl.wait_cnt == code, "write wait length");
        i_ctrl.burst(1'b0, a, code, noq, 4, 1'b0, stop_at, lat);
        check(lat == code + 1 || (var_lat && lat == 2 * code + 2), "read latency");
        for (j = 0; j < 4; j++) check(i_ctrl.rq[j] === wq[j], "read data");
    endtask : wr_rd
    // ==========================================================
    // Test sequence
    initial begin
        srst = 1'b1;
        dpd_enter = 1'b0;
        cfg = '{latency_count: 3'h2, fixed_latency: 1'b1, wait_timing: 1'b0, wrap_en: 1'b0};
        repeat (11) @(posedge sys_clk);
        check(dq_oe === 1'b0 && wait_q === 1'b0 && init_done === 1'b0 && wait_oe === 1'b0,
            "reset values");
        @(posedge sys_clk);
        srst <= 1'b0;
        rel = cyc;
        i_ctrl.idle(2);
        // Nothing is served while the device initializes
        i_ctrl.burst(1'b0, 22'h000010, 2, noq, 1, 1'b0, 0, lat);
        check(lat == 0 && dq_oe === 1'b0, "burst served in init");
        while (init_done !== 1'b1 && cyc - rel < 2000) @(posedge sys_clk);
        check(cyc - rel >= 1500 && cyc - rel <= 1502, "init length");
        $display("test init done");
        // Fixed latency, every code from 0 to 4
        for (int c = 0; c <= 4; c++) begin
            @(posedge sys_clk);
            cfg.latency_count <= 3'(c);
            i_ctrl.idle(8);
            wr_rd(c, 1'b0, 0);
        end
        $display("test fixed latency done");
        // Variable latency, then a read suspended after its second word
        @(posedge sys_clk);
        cfg.fixed_latency <= 1'b0;
        cfg.latency_count <= 3'h2;
        i_ctrl.idle(8);
        wr_rd(2, 1'b1, 0);
        wr_rd(2, 1'b1, 2);
        check(i_ctrl.susp_ok === 1'b1, "suspended data");
        $display("test variable latency done");
        // Write cut by a read, that read cut by another, select held low
        wq = {16'h7e11};
        i_ctrl.burst(1'b1, 22'h000200, 2, wq, 1, 1'b1, 0, lat);
        check(wait_oe === 1'b1, "wait not driven while selected");
        i_ctrl.burst(1'b0, 22'h000200, 2, noq, 1, 1'b1, 0, lat);
        check(i_ctrl.rq[0] === 16'h7e11, "read after cut write");
        i_ctrl.burst(1'b0, 22'h000200, 2, noq, 1, 1'b0, 0, lat);
        check(i_ctrl.rq[0] === 16'h7e11, "read after cut read");
        $display("test interrupt done");
        // Wrap at the row end, upper lane only, early wait timing
        @(posedge sys_clk);
        cfg.fixed_latency <= 1'b1;
        cfg.wait_timing <= 1'b1;
        cfg.wrap_en <= 1'b1;
        i_ctrl.lanes_n = 2'b01;
        i_ctrl.idle(8);
        wq = {16'h55aa, 16'h66bb};
        i_ctrl.burst(1'b1, 22'h00027f, 2, wq, 2, 1'b0, 0, lat);
        i_ctrl.lanes_n = 2'b00;
        i_ctrl.burst(1'b0, 22'h000200, 2, noq, 1, 1'b0, 0, lat);
        check(i_ctrl.rq[0] === 16'h6611, "wrapped lane write");
        check(lat == 3 && i_ctrl.wait_cnt == 2, "early wait timing");
        $display("test wrap and lanes done");
        // Deep sleep: early select low ignored, then a full exit
        @(posedge sys_clk);
        dpd_enter <= 1'b1;
        @(posedge sys_clk);
        dpd_enter <= 1'b0;
        @(posedge sys_clk);
        check(deep_sleep === 1'b1 && init_done === 1'b0, "sleep entry");
        repeat (500) @(posedge sys_clk);
        i_ctrl.select(1'b0);
        repeat (200) @(posedge sys_clk);
        i_ctrl.select(1'b1);
        repeat (800) @(posedge sys_clk);
        check(deep_sleep === 1'b1, "left sleep too early");
        rel = cyc;
        i_ctrl.select(1'b0);
        while (deep_sleep !== 1'b0 && cyc - rel < 300) @(posedge sys_clk);
        check(cyc - rel >= 100 && cyc - rel <= 108, "wake time");
        rel = cyc;
        i_ctrl.select(1'b1);
        while (init_done !== 1'b1 && cyc - rel < 2000) @(posedge sys_clk);
        check(cyc - rel >= 1499 && cyc - rel <= 1502, "init after wake");
        $display("test deep sleep done");
        wrap_up();
    end
    // Watchdog, well past the expected half millisecond of run
    initial begin
        #2000000;
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule : testbench
